// file: logic/ccu_clock_calendar_unit.sv
`timescale 1ns/1ps
`default_nettype none
module ccu_clock_calendar_unit
  import ccu_pkg::*;
#(
  parameter int XTAL_DIVIDE = XTAL_DIV
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic rtc_xtal,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic rtc_out
);

  typedef struct packed {
    logic [2:0] xs;
    logic [14:0] pre;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] wday;
    logic [7:0] day;
    logic [7:0] month;
    logic [7:0] year;
    logic [7:0] asec;
    logic [7:0] amin;
    logic [7:0] ahour;
    logic [7:0] awday;
    logic [7:0] aday;
    logic [7:0] amonth;
    logic on;
    logic unlock;
    logic oe;
    logic [1:0] tptr;
    logic [7:0] cal;
    logic secsel;
    logic aen;
    logic chime;
    logic [3:0] amask;
    logic [1:0] aptr;
    logic [7:0] arpt;
    ccu_key_t key;
    logic bus_wait;
    logic [31:0] rdata;
    logic apulse;
    logic pin;
  } ccu_state_t;

  ccu_state_t q;
  ccu_state_t next_q;
  ccu_req_t req;

  localparam logic [14:0] DIV_LAST = 15'(XTAL_DIVIDE - 1);
  localparam logic [14:0] DIV_HALF = 15'(XTAL_DIVIDE / 2);

  ////////////////////////////////////////////////////////////////////////////
  // BCD helpers.

  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] last,
                                          input logic [7:0] first);
    if (v >= last) begin
      return {1'b1, first};
    end
    if (v[3:0] >= 4'h9) begin
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    end
    return {1'b0, v[7:4], v[3:0] + 4'h1};
  endfunction

  // Within 2000 to 2099 every year divisible by four is a leap year.
  function automatic logic is_leap(input logic [7:0] y);
    if (y[4]) begin
      return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end
    return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction

  function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
    case (m)
      8'h02: month_last = is_leap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
      default: month_last = 8'h31;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Combinational next state.

  logic acc;
  logic acc_rd;
  logic acc_wr;
  logic xedge;
  logic sec_tick;
  logic half_tick;
  logic read_sync;
  logic alarm_hit;
  logic alarm_event;
  logic time_wr;
  logic [8:0] s_sec;
  logic [8:0] s_min;
  logic [8:0] s_hour;
  logic [8:0] s_wday;
  logic [8:0] s_day;
  logic [8:0] s_month;
  logic [8:0] s_year;
  logic [15:0] twin;
  logic [15:0] awin;
  logic [15:0] rd_mux;

  assign req = '{address: avs_address, read: avs_read, write: avs_write,
                 writedata: avs_writedata, byteenable: avs_byteenable};

  always_comb begin
    next_q = q;
    acc = (req.read || req.write) && !q.bus_wait;
    acc_rd = acc && req.read;
    acc_wr = acc && req.write;
    // The first flop feeds only the second; edges are taken further down.
    // crystal timebase sync
    next_q.xs = {q.xs[1:0], rtc_xtal};
    xedge = q.xs[1] && !q.xs[2];
    sec_tick = q.on && xedge && (q.pre == DIV_LAST);
    half_tick = q.on && xedge && (q.pre == DIV_HALF - 15'h0001);
    if (q.on && xedge) begin
      next_q.pre = (q.pre == DIV_LAST) ? 15'h0000 : q.pre + 15'h0001;
    end
    // rollover ripple window
    // A divide shorter than the tail would wrap the subtraction, so the whole second counts as unsafe then.
    read_sync = q.on && ((DIV_LAST < SYNC_TAIL) || (q.pre >= DIV_LAST - SYNC_TAIL));

    s_sec = bcd_step(q.sec, LAST_SEC, RST_ZERO);
    s_min = bcd_step(q.min, LAST_SEC, RST_ZERO);
    s_hour = bcd_step(q.hour, LAST_HOUR, RST_ZERO);
    s_wday = bcd_step(q.wday, LAST_WDAY, RST_ZERO);
    s_day = bcd_step(q.day, month_last(q.month, q.year), RST_DAY);
    s_month = bcd_step(q.month, LAST_MONTH, RST_MONTH);
    s_year = bcd_step(q.year, LAST_YEAR, RST_YEAR);
    if (sec_tick) begin
      next_q.sec = s_sec[7:0];
      if (s_sec[8]) begin
        next_q.min = s_min[7:0];
        if (s_min[8]) begin
          next_q.hour = s_hour[7:0];
          if (s_hour[8]) begin
            next_q.wday = s_wday[7:0];
            next_q.day = s_day[7:0];
            if (s_day[8]) begin
              next_q.month = s_month[7:0];
              if (s_month[8]) begin
                next_q.year = s_year[7:0];
              end
            end
          end
        end
      end
    end

    // Alarm compare; the mask adds fields that must match, wday only at 7, day from 8, and from 4'hA nothing matches.
    alarm_hit = 1'b1;
    if (q.amask >= 4'h2 && q.sec[3:0] != q.asec[3:0]) alarm_hit = 1'b0;
    if (q.amask >= 4'h3 && q.sec[7:4] != q.asec[7:4]) alarm_hit = 1'b0;
    if (q.amask >= 4'h4 && q.min[3:0] != q.amin[3:0]) alarm_hit = 1'b0;
    if (q.amask >= 4'h5 && q.min[7:4] != q.amin[7:4]) alarm_hit = 1'b0;
    if (q.amask >= 4'h6 && q.hour != q.ahour) alarm_hit = 1'b0;
    if (q.amask == 4'h7 && q.wday != q.awday) alarm_hit = 1'b0;
    if (q.amask >= 4'h8 && q.day != q.aday) alarm_hit = 1'b0;
    if (q.amask == 4'h9 && q.month != q.amonth) alarm_hit = 1'b0;
    if (q.amask >= 4'hA) alarm_hit = 1'b0;
    alarm_event = q.aen && alarm_hit && ((q.amask == 4'h0) ? (half_tick || sec_tick) : sec_tick);
    if (alarm_event) begin
      if (q.arpt != 8'h00 || q.chime) begin
        next_q.arpt = q.arpt - 8'h01;
      end else begin
        next_q.aen = 1'b0;
      end
    end
    // The alarm pulse lasts until the next half-second boundary.
    if (alarm_event) begin
      next_q.apulse = 1'b1;
    end else if (half_tick || sec_tick) begin
      next_q.apulse = 1'b0;
    end
    next_q.pin = q.oe && (q.secsel ? (q.pre < DIV_HALF) : q.apulse);

    case (q.tptr)
      2'b00: twin = {q.min, q.sec};
      2'b01: twin = {q.wday, q.hour};
      2'b10: twin = {q.month, q.day};
      default: twin = {8'h00, q.year};
    endcase
    case (q.aptr)
      2'b00: awin = {q.amin, q.asec};
      2'b01: awin = {q.awday, q.ahour};
      2'b10: awin = {q.amonth, q.aday};
      default: awin = 16'h0000;
    endcase
    case (req.address)
      CCU_CFG_OFS: rd_mux = {q.on, 1'b0, q.unlock, read_sync, (q.pre >= DIV_HALF), q.oe, q.tptr, q.cal};
      CCU_PAD_OFS: rd_mux = {14'h0000, q.secsel, 1'b0};
      CCU_ALCFG_OFS: rd_mux = {q.aen, q.chime, q.amask, q.aptr, q.arpt};
      CCU_TWIN_OFS: rd_mux = twin;
      CCU_AWIN_OFS: rd_mux = awin;
      default: rd_mux = 16'h0000;
    endcase

    // One wait state: read data is captured while waitrequest is high.
    next_q.bus_wait = !((req.read || req.write) && q.bus_wait);
    if ((req.read || req.write) && q.bus_wait) begin
      next_q.rdata = {16'h0000, rd_mux};
    end

    // Pointer side effects of window reads.
    if (acc_rd && req.address == CCU_TWIN_OFS && q.tptr != 2'b00) begin
      next_q.tptr = q.tptr - 2'b01;
    end
    if (acc_rd && req.address == CCU_AWIN_OFS && q.aptr != 2'b00) begin
      next_q.aptr = q.aptr - 2'b01;
    end

    // key sequence, armed for the next access only
    case (q.key)
      KEY_IDLE: begin
        if (acc_wr && req.address == CCU_KEY_OFS && req.writedata[7:0] == KEY_FIRST) next_q.key = KEY_GOT1;
      end
      KEY_GOT1: begin
        if (acc_wr && req.address == CCU_KEY_OFS && req.writedata[7:0] == KEY_SECOND) begin
          next_q.key = KEY_ARMED;
        end else if (acc) begin
          next_q.key = KEY_IDLE;
        end
      end
      KEY_ARMED: begin
        if (acc) next_q.key = KEY_IDLE;
      end
      default: next_q.key = KEY_IDLE;
    endcase

    // Software writes come last so that they win over a coincident tick.
    time_wr = acc_wr && req.address == CCU_TWIN_OFS && q.unlock;
    if (acc_wr && req.address == CCU_CFG_OFS) begin
      if (req.byteenable[0]) next_q.cal = req.writedata[7:0];
      if (req.byteenable[1]) begin
        next_q.oe = req.writedata[CFG_OE_BIT];
        next_q.tptr = req.writedata[9:8];
        // unlock only from the armed slot
        if (!req.writedata[CFG_UNLOCK_BIT] || q.key == KEY_ARMED) next_q.unlock = req.writedata[CFG_UNLOCK_BIT];
        if (q.unlock) next_q.on = req.writedata[CFG_ON_BIT];
      end
    end
    if (acc_wr && req.address == CCU_PAD_OFS && req.byteenable[0]) begin
      next_q.secsel = req.writedata[PAD_SECSEL_BIT];
    end
    if (acc_wr && req.address == CCU_ALCFG_OFS) begin
      if (req.byteenable[0]) next_q.arpt = req.writedata[7:0];
      if (req.byteenable[1]) begin
        next_q.aen = req.writedata[ALCFG_EN_BIT];
        next_q.chime = req.writedata[ALCFG_CHIME_BIT];
        next_q.amask = req.writedata[13:10];
        next_q.aptr = req.writedata[9:8];
      end
    end
    if (time_wr) begin
      case (q.tptr)
        2'b00: begin
          if (req.byteenable[1]) next_q.min = req.writedata[15:8];
          if (req.byteenable[0]) begin
            next_q.sec = req.writedata[7:0];
            next_q.pre = 15'h0000;
          end
        end
        2'b01: begin
          if (req.byteenable[1]) next_q.wday = req.writedata[15:8];
          if (req.byteenable[0]) next_q.hour = req.writedata[7:0];
        end
        2'b10: begin
          if (req.byteenable[1]) next_q.month = req.writedata[15:8];
          if (req.byteenable[0]) next_q.day = req.writedata[7:0];
        end
        default: begin
          if (req.byteenable[0]) next_q.year = req.writedata[7:0];
        end
      endcase
    end
    if (acc_wr && req.address == CCU_TWIN_OFS && req.byteenable[1] && q.tptr != 2'b00) begin
      next_q.tptr = q.tptr - 2'b01;
    end
    if (acc_wr && req.address == CCU_AWIN_OFS) begin
      case (q.aptr)
        2'b00: begin
          if (req.byteenable[1]) next_q.amin = req.writedata[15:8];
          if (req.byteenable[0]) next_q.asec = req.writedata[7:0];
        end
        2'b01: begin
          if (req.byteenable[1]) next_q.awday = req.writedata[15:8];
          if (req.byteenable[0]) next_q.ahour = req.writedata[7:0];
        end
        2'b10: begin
          if (req.byteenable[1]) next_q.amonth = req.writedata[15:8];
          if (req.byteenable[0]) next_q.aday = req.writedata[7:0];
        end
        default: ;
      endcase
      if (req.byteenable[1] && q.aptr != 2'b00) begin
        next_q.aptr = q.aptr - 2'b01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= '0;
      q.day <= RST_DAY;
      q.month <= RST_MONTH;
      q.year <= RST_YEAR;
      q.key <= KEY_IDLE;
      q.bus_wait <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.bus_wait;
  assign rtc_out = q.pin;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_hour_range: assert property (q.hour <= LAST_HOUR) else $error("hour out of range");
  a_year_carry: assert property (sec_tick && q.year == 8'h99 && q.month == 8'h12 && q.day == 8'h31 &&
    q.hour == 8'h23 && q.min == 8'h59 && q.sec == 8'h59 && !time_wr |=> q.year == 8'h00 &&
    q.month == 8'h01 && q.day == 8'h01) else $error("century wrap wrong");
  a_leap_day: assert property (sec_tick && !time_wr && q.month == 8'h02 && q.day == 8'h28 &&
    q.hour == 8'h23 && q.min == 8'h59 && q.sec == 8'h59 |=> q.day == (is_leap(q.year) ? 8'h29 : 8'h01))
    else $error("leap day wrong");
  a_tptr_write: assert property (acc_wr && req.address == CCU_TWIN_OFS && req.byteenable[1] &&
    q.tptr != 2'b00 |=> q.tptr == $past(q.tptr) - 2'b01) else $error("time pointer not decremented");
  a_aptr_read: assert property (acc_rd && req.address == CCU_AWIN_OFS && q.aptr != 2'b00 |=>
    q.aptr == $past(q.aptr) - 2'b01) else $error("alarm pointer not decremented");
  a_time_locked: assert property (acc_wr && req.address == CCU_TWIN_OFS && !q.unlock && !sec_tick |=>
    $stable(q.min) && $stable(q.sec) && $stable(q.hour)) else $error("locked time written");
  a_unlock_key: assert property ($rose(q.unlock) |-> $past(q.key) == KEY_ARMED)
    else $error("unlock set without key");
  a_enable_gate: assert property (q.on != $past(q.on) |-> $past(q.unlock)) else $error("enable changed while locked");
  a_half_clear: assert property (time_wr && q.tptr == 2'b00 && req.byteenable[0] |=> q.pre < DIV_HALF)
    else $error("half flag not cleared");
  a_sync_tick: assert property (sec_tick |-> read_sync) else $error("tick outside sync window");
  a_bus_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held too long");

  c_unlock: cover property ($rose(q.unlock));
  c_minute_carry: cover property (sec_tick && q.sec == 8'h59);
  c_alarm: cover property (alarm_event);
  c_ptr_walk: cover property (acc_rd && req.address == CCU_TWIN_OFS ##[1:20] q.tptr == 2'b00);

endmodule
`default_nettype wire

// file: shared/ccu_pkg.sv
package ccu_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [4:0] CCU_CFG_OFS = 5'h00;
  localparam logic [4:0] CCU_PAD_OFS = 5'h04;
  localparam logic [4:0] CCU_ALCFG_OFS = 5'h08;
  localparam logic [4:0] CCU_TWIN_OFS = 5'h0C;
  localparam logic [4:0] CCU_AWIN_OFS = 5'h10;
  localparam logic [4:0] CCU_KEY_OFS = 5'h14;

  // Field positions in the configuration, pad and alarm configuration registers.
  localparam int CFG_ON_BIT = 15;
  localparam int CFG_UNLOCK_BIT = 13;
  localparam int CFG_SYNC_BIT = 12;
  localparam int CFG_HALF_BIT = 11;
  localparam int CFG_OE_BIT = 10;
  localparam int PAD_SECSEL_BIT = 1;
  localparam int ALCFG_EN_BIT = 15;
  localparam int ALCFG_CHIME_BIT = 14;

  // Unlock key bytes.
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // Timebase: crystal edges per second and the tail where reads are unsafe.
  localparam int XTAL_DIV = 32768;
  localparam logic [14:0] SYNC_TAIL = 15'h0020;

  // Reset values of the calendar, midnight of the first day.
  localparam logic [7:0] RST_DAY = 8'h01;
  localparam logic [7:0] RST_MONTH = 8'h01;
  localparam logic [7:0] RST_YEAR = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // BCD limits.
  localparam logic [7:0] LAST_SEC = 8'h59;
  localparam logic [7:0] LAST_HOUR = 8'h23;
  localparam logic [7:0] LAST_WDAY = 8'h06;
  localparam logic [7:0] LAST_MONTH = 8'h12;
  localparam logic [7:0] LAST_YEAR = 8'h99;

  typedef enum logic [2:0] {
    KEY_IDLE = 3'b001,
    KEY_GOT1 = 3'b010,
    KEY_ARMED = 3'b100
  } ccu_key_t;

  // Avalon-MM request bundle.
  typedef struct packed {
    logic [4:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } ccu_req_t;

endpackage

// file: dv/clock_calendar_register_window_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module clock_calendar_register_window_tb
  import ccu_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////////
  // A divide of 4 keeps one second at a few dozen clocks instead of 32768 edges.
  localparam int DIV = 4;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic rtc_xtal = 1'b0;
  ccu_req_t req = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rtc_out;
  int n_mismatch = 0;
  int checked = 0;
  logic [15:0] q;

  always #4 clk = ~clk;

  ccu_clock_calendar_unit #(.XTAL_DIVIDE(DIV)) dut_u (
    .clk(clk),
    .rst_b(rst_b),
    .rtc_xtal(rtc_xtal),
    .avs_address(req.address),
    .avs_read(req.read),
    .avs_write(req.write),
    .avs_writedata(req.writedata),
    .avs_byteenable(req.byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .rtc_out(rtc_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // The request is held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d, input logic [3:0] be,
                     output logic [15:0] rq);
    int n;
    n = 0;
    @(posedge clk);
    req.address <= a;
    req.read <= ~wr;
    req.write <= wr;
    req.writedata <= {16'h0000, d};
    req.byteenable <= be;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rq = avs_readdata[15:0];
    if (n >= 50) begin
      n_mismatch++;
      $display("MISMATCH waitrequest expected 0 seen %b", avs_waitrequest);
    end
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] x;
    bus(1'b1, a, d, 4'h3, x);
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    bus(1'b0, a, 16'h0000, 4'h3, v);
  endtask

  task automatic rd_chk(input string nm, input logic [4:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    `CHK(nm, e, v)
  endtask

  // Crystal edges are made slow against clk so the two-flop sync sees each one.
  task automatic xtal(input int n);
    repeat (n) begin
      @(posedge clk);
      rtc_xtal <= 1'b1;
      repeat (4) @(posedge clk);
      rtc_xtal <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(CCU_CFG_OFS, q);
    `CHK("cfg_reset", 16'h0000, q & 16'hE7FF)
    `CHK("read_sync_off", 1'b0, q[CFG_SYNC_BIT])
    rd_chk("pad_reset", CCU_PAD_OFS, 16'h0000);
    rd_chk("alcfg_reset", CCU_ALCFG_OFS, 16'h0000);
    rd_chk("minutes_seconds_pair_reset", CCU_TWIN_OFS, 16'h0000);
    rd_chk("unmapped", 5'h18, 16'h0000);
    wr(5'h1C, 16'hFFFF);
    rd_chk("unmapped_wr", 5'h1C, 16'h0000);
  endtask

  task automatic t_pointer;
    logic [15:0] exp_v [4];
    logic [1:0] exp_p [4];
    exp_v = '{16'h0000, 16'h0101, 16'h0000, 16'h0000};
    exp_p = '{2'b10, 2'b01, 2'b00, 2'b00};
    wr(CCU_CFG_OFS, 16'h0300);
    for (int i = 0; i < 4; i++) begin
      rd_chk("twin_read", CCU_TWIN_OFS, exp_v[i]);
      rd(CCU_CFG_OFS, q);
      `CHK("time_ptr", exp_p[i], q[9:8])
    end
  endtask

  task automatic t_lock;
    wr(CCU_TWIN_OFS, 16'h1234);
    rd_chk("locked_minutes_seconds_pair", CCU_TWIN_OFS, 16'h0000);
    wr(CCU_CFG_OFS, 16'h0200);
    wr(CCU_TWIN_OFS, 16'h1111);
    rd(CCU_CFG_OFS, q);
    `CHK("ptr_after_wr", 2'b01, q[9:8])
    rd_chk("locked_wdhr", CCU_TWIN_OFS, 16'h0000);
    wr(CCU_CFG_OFS, 16'hA000);
    rd(CCU_CFG_OFS, q);
    `CHK("no_key", 3'b000, q[15:13])
    wr(CCU_KEY_OFS, {8'h00, KEY_FIRST});
    wr(CCU_KEY_OFS, {8'h00, KEY_SECOND});
    rd(CCU_CFG_OFS, q);
    wr(CCU_CFG_OFS, 16'hA000);
    rd(CCU_CFG_OFS, q);
    `CHK("late_set", 3'b000, q[15:13])
    wr(CCU_KEY_OFS, {8'h00, KEY_FIRST});
    wr(CCU_KEY_OFS, {8'h00, KEY_SECOND});
    wr(CCU_CFG_OFS, 16'hA000);
    rd(CCU_CFG_OFS, q);
    // The keyed write sets only the unlock bit; enable needs unlock already set.
    `CHK("keyed_set", 3'b001, q[15:13])
    wr(CCU_CFG_OFS, 16'hA000);
    rd(CCU_CFG_OFS, q);
    `CHK("enable_set", 3'b101, q[15:13])
  endtask

  task automatic t_alarm;
    logic [15:0] exp_v [5];
    exp_v = '{16'h0000, 16'h0115, 16'h0223, 16'h3045, 16'h3045};
    wr(CCU_ALCFG_OFS, 16'h0200);
    wr(CCU_AWIN_OFS, 16'h0115);
    rd(CCU_ALCFG_OFS, q);
    `CHK("alarm_ptr", 2'b01, q[9:8])
    wr(CCU_AWIN_OFS, 16'h0223);
    wr(CCU_AWIN_OFS, 16'h3045);
    rd(CCU_ALCFG_OFS, q);
    `CHK("alarm_ptr_floor", 2'b00, q[9:8])
    wr(CCU_ALCFG_OFS, 16'h0300);
    for (int i = 0; i < 5; i++) begin
      rd_chk("awin_read", CCU_AWIN_OFS, exp_v[i]);
    end
  endtask

  // Last second of Feb 28 at 23:59:59 rolls into Feb 29 only in leap years.
  task automatic t_calendar;
    logic [7:0] yr [3];
    logic [15:0] md [3];
    yr = '{8'h24, 8'h23, 8'h00};
    md = '{16'h0229, 16'h0301, 16'h0229};
    for (int i = 0; i < 3; i++) begin
      wr(CCU_CFG_OFS, 16'hA300);
      wr(CCU_TWIN_OFS, {8'h00, yr[i]});
      wr(CCU_TWIN_OFS, 16'h0228);
      wr(CCU_TWIN_OFS, 16'h0323);
      wr(CCU_TWIN_OFS, 16'h5959);
      xtal(DIV);
      wr(CCU_CFG_OFS, 16'hA300);
      rd_chk("year", CCU_TWIN_OFS, {8'h00, yr[i]});
      rd_chk("month_day", CCU_TWIN_OFS, md[i]);
      rd_chk("wday_hour", CCU_TWIN_OFS, 16'h0400);
      rd_chk("min_sec", CCU_TWIN_OFS, 16'h0000);
    end
  endtask

  task automatic t_output;
    wr(CCU_PAD_OFS, 16'h0002);
    wr(CCU_CFG_OFS, 16'hA400);
    bus(1'b1, CCU_TWIN_OFS, 16'h0000, 4'h1, q);
    repeat (3) @(posedge clk);
    `CHK("sec_clk_high", 1'b1, rtc_out)
    rd(CCU_CFG_OFS, q);
    `CHK("first_half", 1'b0, q[CFG_HALF_BIT])
    `CHK("read_sync_on", 1'b1, q[CFG_SYNC_BIT])
    xtal(DIV / 2);
    rd(CCU_CFG_OFS, q);
    `CHK("second_half", 1'b1, q[CFG_HALF_BIT])
    `CHK("sec_clk_low", 1'b0, rtc_out)
    bus(1'b1, CCU_TWIN_OFS, 16'h0000, 4'h1, q);
    rd(CCU_CFG_OFS, q);
    `CHK("half_cleared", 1'b0, q[CFG_HALF_BIT])
    wr(CCU_CFG_OFS, 16'h8000);
    repeat (3) @(posedge clk);
    `CHK("pin_disabled", 1'b0, rtc_out)
    rd(CCU_CFG_OFS, q);
    `CHK("relocked", 3'b100, q[15:13])
    wr(CCU_TWIN_OFS, 16'h4444);
    rd_chk("relocked_minutes_seconds_pair", CCU_TWIN_OFS, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // The whole run takes a few hundred clocks, so this limit only cuts a hang.
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("MISMATCH watchdog expected done seen hang");
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_pointer();
    t_lock();
    t_alarm();
    t_calendar();
    t_output();
    give_verdict();
  end
endmodule
`default_nettype wire
